// ===== logic/nvpl_pkg.sv
package nvpl_pkg;

   // ======================================================================
   // Object subindex selectors
   // ======================================================================
   localparam logic [1:0] NVPL_SI_COMMAND  = 2'h1;   // Command subindex
   localparam logic [1:0] NVPL_SI_STATUS   = 2'h2;   // Status subindex
   localparam logic [1:0] NVPL_SI_RESPONSE = 2'h3;   // Response subindex

   // ======================================================================
   // Load key, byte 0 in the low lane
   // ======================================================================
   localparam logic [7:0] NVPL_KEY_B0 = 8'h6C;
   localparam logic [7:0] NVPL_KEY_B1 = 8'h6F;
   localparam logic [7:0] NVPL_KEY_B2 = 8'h61;
   localparam logic [7:0] NVPL_KEY_B3 = 8'h64;

   // ======================================================================
   // Status codes
   // ======================================================================
   localparam logic [7:0] NVPL_ST_OK_NORESP = 8'h00;  // Load done, no error
   localparam logic [7:0] NVPL_ST_IDLE      = 8'h00;  // Checksum never started
   localparam logic [7:0] NVPL_ST_OK_REPLY  = 8'h01;  // Checksum done, result
   localparam logic [7:0] NVPL_ST_ERROR     = 8'h02;  // Done with error
   localparam logic [7:0] NVPL_ST_BUSY      = 8'hFF;  // Executing

   // ======================================================================
   // Checksum command bit positions
   // ======================================================================
   localparam int NVPL_BIT_DEFAULT = 0;   // Default algorithm / nv supported
   localparam int NVPL_BIT_SEL1    = 1;   // Second bit of selection range
   localparam int NVPL_BIT_OTHER   = 7;   // Other algorithm

   // ======================================================================
   // Carriers
   // ======================================================================
   // Host access to one subindex of one object
   typedef struct packed {
      logic        wr;      // Write strobe, one cycle
      logic        rd;      // Read strobe, one cycle
      logic        csum;    // 1 = checksum object, 0 = load object
      logic [1:0]  si;      // Subindex
      logic [31:0] wdata;   // Write bytes, byte 0 in bits 7:0
   } nvpl_req_t;

   // Storage read port toward the parameter memory
   typedef struct packed {
      logic        req;     // Word request, one cycle
      logic [7:0]  addr;    // Word index
   } nvpl_mem_req_t;

endpackage : nvpl_pkg

// ===== logic/nvpl_sum_acc.sv
`timescale 1ns/1ps
module nvpl_sum_acc
   import nvpl_pkg::*;
#(
   parameter int W = 32
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         clear,
   input  wire logic         add_en,
   input  wire logic         alt_alg,
   input  wire logic [W-1:0] word,
   output logic      [W-1:0] sum
);

   // Width check, the rotate needs two bits at least
   if (W < 2) begin : g_bad_width
      $error("W below 2");
   end

   // ======================================================================
   // Accumulator
   // ======================================================================
   logic [W-1:0] sum_reg;   // Running checksum

   // Default: additive; other: rotate then xor
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sum_reg <= '0;
      end else if (clear) begin
         sum_reg <= '0;
      end else if (add_en) begin
         if (alt_alg) begin
            sum_reg <= {sum_reg[W-2:0], sum_reg[W-1]} ^ word;
         end else begin
            sum_reg <= sum_reg + word;
         end
      end
   end

   assign sum = sum_reg;

endmodule : nvpl_sum_acc

// ===== logic/nvpl_cmd.sv
`timescale 1ns/1ps
// Contract
// - Matching load key reloads non-volatile parameters
// - Auto-save device completes load without action
// - Load status 0 ok, 2 error, 255 busy
// - Response byte 0 copies status
// - Checksum covers stored, not working, parameters
// - Command read returns capability bits 0, 7
// - Command write selects algorithm, starts checksum
// - Checksum status 0 idle, 1, 2, 255
// - Response: status, zero, four checksum bytes
module nvpl_cmd
   import nvpl_pkg::*;
#(
   parameter int NV_WORDS  = 16,   // Stored parameter words
   parameter bit AUTO_SAVE = 1'b0, // Device saves on every write
   parameter bit NV_SUPP   = 1'b1, // Non-volatile parameters present
   parameter bit ALT_SUPP  = 1'b1  // Other algorithm offered
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire nvpl_req_t     req,
   output logic      [47:0]   rdata,
   output logic               rvalid,
   output nvpl_mem_req_t      mem_req,
   input  wire logic          mem_ack,
   input  wire logic [31:0]   mem_word,
   output logic               reload_req,
   input  wire logic          reload_done,
   input  wire logic          reload_err
);

   // Parameter range check, word index is eight bits
   if (NV_WORDS < 1 || NV_WORDS > 256) begin : g_bad_words
      $error("NV_WORDS out of range");
   end

   // ======================================================================
   // State
   // ======================================================================
   typedef enum logic [1:0] {NVPL_L_IDLE, NVPL_L_WAIT} nvpl_lstate_t;
   typedef enum logic [1:0] {NVPL_C_IDLE, NVPL_C_REQ, NVPL_C_WAIT} nvpl_cstate_t;

   nvpl_lstate_t lstate_reg;        // Load sequencer
   nvpl_cstate_t cstate_reg;        // Checksum sequencer
   logic [7:0]   lstat_reg;         // Load status
   logic [7:0]   cstat_reg;         // Checksum status
   logic [31:0]  lcmd_reg;          // Last load command bytes
   logic [7:0]   addr_reg;          // Storage word index
   logic [31:0]  result_reg;        // Latched checksum
   logic         reload_reg;        // Reload request pulse
   logic [47:0]  rdata_reg;         // Read data
   logic         rvalid_reg;        // Read answer strobe
   logic         sel_alt_reg;       // Other algorithm chosen
   logic [31:0]  acc_sum;           // Accumulator output
   logic         acc_clear;         // Accumulator restart
   logic         acc_add;           // Accumulate one word

   // Decoded writes
   logic load_wr;
   logic csum_wr;
   logic key_ok;
   logic sel_ok;
   logic last_word;

   assign load_wr   = req.wr && !req.csum && (req.si == NVPL_SI_COMMAND);
   assign csum_wr   = req.wr && req.csum && (req.si == NVPL_SI_COMMAND);
   assign key_ok    = (req.wdata == {NVPL_KEY_B3, NVPL_KEY_B2, NVPL_KEY_B1, NVPL_KEY_B0});
   // Exactly one of the selection bits, and a supported one
   assign sel_ok    = (req.wdata[NVPL_BIT_DEFAULT] ^ req.wdata[NVPL_BIT_OTHER])
                      && !req.wdata[NVPL_BIT_SEL1]
                      && (!req.wdata[NVPL_BIT_OTHER] || ALT_SUPP) && NV_SUPP;
   assign last_word = (addr_reg == 8'(NV_WORDS - 1));

   // ======================================================================
   // Load command
   // ======================================================================
   // Key check, reload request and status tracking
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lstate_reg <= NVPL_L_IDLE;
         lstat_reg  <= NVPL_ST_OK_NORESP;
         lcmd_reg   <= '0;
         reload_reg <= 1'b0;
      end else begin
         reload_reg <= 1'b0;
         case (lstate_reg)
            NVPL_L_IDLE: begin
               if (load_wr) begin
                  lcmd_reg <= req.wdata;
                  if (!key_ok) begin
                     lstat_reg <= NVPL_ST_ERROR;
                  end else if (AUTO_SAVE) begin
                     lstat_reg <= NVPL_ST_OK_NORESP;
                  end else begin
                     reload_reg <= 1'b1;
                     lstat_reg  <= NVPL_ST_BUSY;
                     lstate_reg <= NVPL_L_WAIT;
                  end
               end
            end
            NVPL_L_WAIT: begin
               if (reload_done) begin
                  lstat_reg  <= reload_err ? NVPL_ST_ERROR : NVPL_ST_OK_NORESP;
                  lstate_reg <= NVPL_L_IDLE;
               end
            end
            default: lstate_reg <= NVPL_L_IDLE;
         endcase
      end
   end

   assign reload_req = reload_reg;

   // ======================================================================
   // Checksum command
   // ======================================================================
   // Walks stored words; writes while busy are ignored
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cstate_reg  <= NVPL_C_IDLE;
         cstat_reg   <= NVPL_ST_IDLE;
         addr_reg    <= '0;
         result_reg  <= '0;
         sel_alt_reg <= 1'b0;
      end else begin
         case (cstate_reg)
            NVPL_C_IDLE: begin
               if (csum_wr) begin
                  if (!sel_ok) begin
                     cstat_reg <= NVPL_ST_ERROR;
                  end else begin
                     sel_alt_reg <= req.wdata[NVPL_BIT_OTHER];
                     addr_reg    <= '0;
                     cstat_reg   <= NVPL_ST_BUSY;
                     cstate_reg  <= NVPL_C_REQ;
                  end
               end
            end
            NVPL_C_REQ: begin
               cstate_reg <= NVPL_C_WAIT;
            end
            NVPL_C_WAIT: begin
               if (mem_ack) begin
                  if (last_word) begin
                     result_reg <= (sel_alt_reg ? {acc_sum[30:0], acc_sum[31]} ^ mem_word
                                                : acc_sum + mem_word);
                     cstat_reg  <= NVPL_ST_OK_REPLY;
                     cstate_reg <= NVPL_C_IDLE;
                  end else begin
                     addr_reg   <= addr_reg + 8'h01;
                     cstate_reg <= NVPL_C_REQ;
                  end
               end
            end
            default: cstate_reg <= NVPL_C_IDLE;
         endcase
      end
   end

   assign acc_clear = csum_wr && (cstate_reg == NVPL_C_IDLE);
   assign acc_add   = (cstate_reg == NVPL_C_WAIT) && mem_ack;
   assign mem_req.req  = (cstate_reg == NVPL_C_REQ);
   assign mem_req.addr = addr_reg;

   nvpl_sum_acc #(
      .W       (32)
   ) u_acc (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (acc_clear),
      .add_en  (acc_add),
      .alt_alg (sel_alt_reg),
      .word    (mem_word),
      .sum     (acc_sum)
   );

   // ======================================================================
   // Read path
   // ======================================================================
   // Answer one cycle after the read strobe
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg  <= '0;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= req.rd;
         if (req.rd) begin
            rdata_reg <= '0;
            if (req.csum) begin
               case (req.si)
                  NVPL_SI_COMMAND:  rdata_reg[7:0] <= {ALT_SUPP, 6'h00, NV_SUPP};
                  NVPL_SI_STATUS:   rdata_reg[7:0] <= cstat_reg;
                  NVPL_SI_RESPONSE: rdata_reg <= {result_reg, 8'h00, cstat_reg};
                  default:          rdata_reg <= '0;
               endcase
            end else begin
               case (req.si)
                  NVPL_SI_COMMAND:  rdata_reg[31:0] <= lcmd_reg;
                  NVPL_SI_STATUS:   rdata_reg[7:0]  <= lstat_reg;
                  NVPL_SI_RESPONSE: rdata_reg[7:0]  <= lstat_reg;
                  default:          rdata_reg <= '0;
               endcase
            end
         end
      end
   end

   assign rdata  = rdata_reg;
   assign rvalid = rvalid_reg;

   // ======================================================================
   // Checks
   // ======================================================================
   property p_load_key;
      @(posedge clk) disable iff (sys_rst)
      (load_wr && key_ok && !AUTO_SAVE && lstate_reg == NVPL_L_IDLE) |=> reload_req;
   endproperty
   a_load_key: assert property (p_load_key) else $error("key did not start reload");

   property p_bad_key;
      @(posedge clk) disable iff (sys_rst)
      (load_wr && !key_ok && lstate_reg == NVPL_L_IDLE) |=> !reload_req && lstat_reg == NVPL_ST_ERROR;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("bad key not refused");

   property p_load_codes;
      @(posedge clk) disable iff (sys_rst)
      lstat_reg == NVPL_ST_OK_NORESP || lstat_reg == NVPL_ST_ERROR || lstat_reg == NVPL_ST_BUSY;
   endproperty
   a_load_codes: assert property (p_load_codes) else $error("reserved load status");

   property p_busy_wait;
      @(posedge clk) disable iff (sys_rst)
      (lstate_reg == NVPL_L_WAIT) |-> lstat_reg == NVPL_ST_BUSY;
   endproperty
   a_busy_wait: assert property (p_busy_wait) else $error("load busy code lost");

   property p_resp_copy;
      @(posedge clk) disable iff (sys_rst)
      (req.rd && req.si == NVPL_SI_RESPONSE)
         |=> rdata[7:0] == ($past(req.csum) ? $past(cstat_reg) : $past(lstat_reg));
   endproperty
   a_resp_copy: assert property (p_resp_copy) else $error("response byte 0 differs");

   property p_resp_zero;
      @(posedge clk) disable iff (sys_rst)
      (req.rd && req.csum && req.si == NVPL_SI_RESPONSE) |=> rdata[15:8] == 8'h00;
   endproperty
   a_resp_zero: assert property (p_resp_zero) else $error("response byte 1 not zero");

   property p_start;
      @(posedge clk) disable iff (sys_rst)
      (csum_wr && sel_ok && cstate_reg == NVPL_C_IDLE)
         |=> cstat_reg == NVPL_ST_BUSY && mem_req.req && mem_req.addr == 8'h00;
   endproperty
   a_start: assert property (p_start) else $error("checksum did not start");

   property p_csum_busy;
      @(posedge clk) disable iff (sys_rst)
      (cstate_reg != NVPL_C_IDLE) |-> cstat_reg == NVPL_ST_BUSY;
   endproperty
   a_csum_busy: assert property (p_csum_busy) else $error("checksum busy code lost");

   property p_autosave;
      @(posedge clk) disable iff (sys_rst)
      (load_wr && key_ok && AUTO_SAVE && lstate_reg == NVPL_L_IDLE)
         |=> !reload_req && lstat_reg == NVPL_ST_OK_NORESP;
   endproperty
   a_autosave: assert property (p_autosave) else $error("auto-save load not immediate");

   property p_cap_read;
      @(posedge clk) disable iff (sys_rst)
      (req.rd && req.csum && req.si == NVPL_SI_COMMAND)
         |=> rdata[NVPL_BIT_DEFAULT] == NV_SUPP && rdata[NVPL_BIT_OTHER] == ALT_SUPP;
   endproperty
   a_cap_read: assert property (p_cap_read) else $error("capability flags wrong");

   property p_bad_sel;
      @(posedge clk) disable iff (sys_rst)
      (csum_wr && !sel_ok && cstate_reg == NVPL_C_IDLE) |=> cstat_reg == NVPL_ST_ERROR && !mem_req.req;
   endproperty
   a_bad_sel: assert property (p_bad_sel) else $error("bad selection not refused");

   property p_csum_done;
      @(posedge clk) disable iff (sys_rst)
      (cstate_reg == NVPL_C_WAIT && mem_ack && last_word)
         |=> cstat_reg == NVPL_ST_OK_REPLY && cstate_reg == NVPL_C_IDLE;
   endproperty
   a_csum_done: assert property (p_csum_done) else $error("checksum did not finish");

   property p_csum_codes;
      @(posedge clk) disable iff (sys_rst)
      cstat_reg == NVPL_ST_IDLE || cstat_reg == NVPL_ST_OK_REPLY || cstat_reg == NVPL_ST_ERROR
         || cstat_reg == NVPL_ST_BUSY;
   endproperty
   a_csum_codes: assert property (p_csum_codes) else $error("reserved checksum status");

endmodule : nvpl_cmd

// ===== sim/nvpl_mem_model.sv
`timescale 1ns/1ps
module nvpl_mem_model
   import nvpl_pkg::*;
#(
   parameter int NV_WORDS = 8   // Stored parameter words
) (
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire nvpl_mem_req_t mem_req,
   output logic               mem_ack,
   output logic      [31:0]   mem_word,
   input  wire logic          reload_req,
   output logic               reload_done,
   output logic               reload_err,
   input  wire logic          err_mode
);
   // ======================================================================
   // Storage side of the parameter memory
   // ======================================================================
   logic        pending;     // One word outstanding
   logic [7:0]  addr_reg;    // Word being fetched
   logic [31:0] last_word;   // Last word handed out
   int          wait_cnt;    // Cycles left before the answer
   int          rl_cnt;      // Reload cycles left

   // Content of stored word a
   function automatic logic [31:0] word_at(input logic [7:0] a);
      return 32'h1000_0000 + a * 32'h0101_0103;
   endfunction : word_at

   // Word fetch, fast on odd words and slow on even ones
   // stored copy only
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pending   <= 1'b0;
         addr_reg  <= 8'h00;
         last_word <= 32'h0000_0000;
         wait_cnt  <= 0;
         mem_ack   <= 1'b0;
         mem_word  <= 32'h0000_0000;
      end else begin
         mem_ack  <= 1'b0;
         // Data lines hold no stale value outside the answer
         mem_word <= ~last_word;
         if (mem_req.req) begin
            pending  <= 1'b1;
            addr_reg <= mem_req.addr;
            wait_cnt <= mem_req.addr[0] ? 0 : 2;
         end else if (pending && wait_cnt == 0) begin
            mem_ack   <= 1'b1;
            mem_word  <= word_at(addr_reg);
            last_word <= word_at(addr_reg);
            pending   <= 1'b0;
         end else if (pending) begin
            wait_cnt <= wait_cnt - 1;
         end
      end
   end

   // Reload handshake, error taken from the bench
   // reload answer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rl_cnt      <= 0;
         reload_done <= 1'b0;
         reload_err  <= 1'b0;
      end else begin
         if (reload_req) begin
            rl_cnt <= 3;
         end else if (rl_cnt > 0) begin
            rl_cnt <= rl_cnt - 1;
         end
         reload_done <= (rl_cnt == 1);
         reload_err  <= (rl_cnt == 1) ? err_mode : ~err_mode;
      end
   end
endmodule : nvpl_mem_model

// ===== sim/nv_param_load_checksum_cmds_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module nv_param_load_checksum_cmds_tb
   import nvpl_pkg::*;
;
   // ======================================================================
   // Signals
   // ======================================================================
   localparam int NW = 8;         // Shortened stored word count
   logic          clk;            // Device clock
   logic          sys_rst;        // Async reset
   nvpl_req_t     req;            // Register access
   logic [47:0]   rdata;          // Read data
   logic          rvalid;         // Read answer
   nvpl_mem_req_t mem_req;        // Storage request
   logic          mem_ack;        // Storage answer
   logic [31:0]   mem_word;       // Storage data
   logic          reload_req;     // Reload request
   logic          reload_done;    // Reload finished
   logic          reload_err;     // Reload failed
   logic          err_mode;       // Model makes reload fail
   int            fail_count;     // Mismatches
   int            n_tests;        // Comparisons
   int            reloads = 0;    // Reload requests seen
   logic [47:0]   rdata_sv;       // Read data, auto-save build
   logic          reload_req_sv;  // Reload request, auto-save build
   int            reloads_sv = 0; // Reload requests, auto-save build

   nvpl_cmd #(.NV_WORDS(NW)) uut (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
      .rvalid(rvalid), .mem_req(mem_req), .mem_ack(mem_ack), .mem_word(mem_word),
      .reload_req(reload_req), .reload_done(reload_done), .reload_err(reload_err));
   nvpl_mem_model #(.NV_WORDS(NW)) mem (.clk(clk), .sys_rst(sys_rst), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_word(mem_word), .reload_req(reload_req),
      .reload_done(reload_done), .reload_err(reload_err), .err_mode(err_mode));
   // Auto-save build on the same bus, storage answers shared
   nvpl_cmd #(.NV_WORDS(NW), .AUTO_SAVE(1'b1)) uut_save (.clk(clk), .sys_rst(sys_rst), .req(req),
      .rdata(rdata_sv), .rvalid(), .mem_req(), .mem_ack(mem_ack), .mem_word(mem_word),
      .reload_req(reload_req_sv), .reload_done(1'b0), .reload_err(1'b0));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Count reload pulses
   always @(posedge clk) begin
      if (reload_req === 1'b1) reloads++;
      if (reload_req_sv === 1'b1) reloads_sv++;
   end

   // ======================================================================
   // Bus tasks
   // ======================================================================
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run

   task automatic wr(input logic c, input logic [31:0] d);
      @(posedge clk); #2;
      req = '{wr: 1'b1, rd: 1'b0, csum: c, si: NVPL_SI_COMMAND, wdata: d};
      @(posedge clk); #2;
      req.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic c, input logic [1:0] s, output logic [47:0] d);
      @(posedge clk); #2;
      req = '{wr: 1'b0, rd: 1'b1, csum: c, si: s, wdata: 32'h0000_0000};
      @(posedge clk); #2;
      req.rd = 1'b0;
      `CHK("rvalid", 1'b1, rvalid)
      d = rdata;
   endtask : rd

   // Poll status until it leaves busy, bounded
   task automatic poll(input logic c, output logic [7:0] st);
      logic [47:0] d;
      for (int i = 0; i < 100; i++) begin
         rd(c, NVPL_SI_STATUS, d);
         st = d[7:0];
         if (st !== NVPL_ST_BUSY) return;
      end
      fail_count++;
      complete_run();
   endtask : poll

   // ======================================================================
   // Scenarios
   // ======================================================================
   task automatic t_idle();
      logic [47:0] d;
      rd(1'b1, NVPL_SI_STATUS, d);
      `CHK("checksum idle", NVPL_ST_IDLE, d[7:0])
      rd(1'b0, NVPL_SI_STATUS, d);
      `CHK("load idle", NVPL_ST_OK_NORESP, d[7:0])
      // Capability flags
      rd(1'b1, NVPL_SI_COMMAND, d);
      `CHK("capability", 8'h81, d[7:0])
      $display("idle and capability test done");
   endtask : t_idle

   task automatic t_load(input logic [31:0] key, input logic e, input logic [7:0] ex, input int nrl);
      logic [47:0] d;
      logic [7:0]  st;
      int          r0;
      err_mode = e;
      r0 = reloads;
      wr(1'b0, key);
      rd(1'b0, NVPL_SI_STATUS, d);
      if (nrl == 1) `CHK("load busy", NVPL_ST_BUSY, d[7:0])
      `CHK("autosave status", (nrl == 1) ? NVPL_ST_OK_NORESP : NVPL_ST_ERROR, rdata_sv[7:0])
      // Wrong key while reloading is ignored
      if (nrl == 1) wr(1'b0, 32'h0000_0000);
      poll(1'b0, st);
      `CHK("load status", ex, st)
      `CHK("reload count", nrl, reloads - r0)
      rd(1'b0, NVPL_SI_RESPONSE, d);
      `CHK("load response", ex, d[7:0])
      rd(1'b0, NVPL_SI_COMMAND, d);
      `CHK("load command", key, d[31:0])
      `CHK("autosave reloads", 0, reloads_sv)
      $display("load test key %h done", key);
   endtask : t_load

   task automatic t_csum(input logic [31:0] sel, input logic [7:0] ex);
      logic [47:0] d;
      logic [7:0]  st;
      logic [31:0] s;
      s = 32'h0000_0000;
      for (int i = 0; i < NW; i++) begin
         if (sel[NVPL_BIT_OTHER]) s = {s[30:0], s[31]} ^ (32'h1000_0000 + i * 32'h0101_0103);
         else s = s + (32'h1000_0000 + i * 32'h0101_0103);
      end
      wr(1'b1, sel);
      rd(1'b1, NVPL_SI_STATUS, d);
      `CHK("checksum first status", (ex == NVPL_ST_OK_REPLY) ? NVPL_ST_BUSY : ex, d[7:0])
      // Other selection while busy is ignored
      if (ex == NVPL_ST_OK_REPLY) wr(1'b1, sel ^ 32'h0000_0081);
      poll(1'b1, st);
      `CHK("checksum status", ex, st)
      rd(1'b1, NVPL_SI_RESPONSE, d);
      `CHK("checksum byte0", ex, d[7:0])
      `CHK("checksum byte1", 8'h00, d[15:8])
      if (ex == NVPL_ST_OK_REPLY) `CHK("checksum value", s, d[47:16])
      $display("checksum test select %h done", sel);
   endtask : t_csum

   // ======================================================================
   // Main sequence
   // ======================================================================
   initial begin
      fail_count = 0;
      n_tests    = 0;
      err_mode   = 1'b0;
      req        = '0;
      sys_rst    = 1'b1;
      repeat (2) @(posedge clk);
      #2 sys_rst = 1'b0;
      // Statuses and capability after reset
      t_idle();
      t_load(32'h6461_6F6C, 1'b0, NVPL_ST_OK_NORESP, 1);
      t_load(32'h6461_6F6C, 1'b1, NVPL_ST_ERROR, 1);
      t_load(32'h6461_6F6D, 1'b0, NVPL_ST_ERROR, 0);
      t_csum(32'h0000_0001, NVPL_ST_OK_REPLY);
      t_csum(32'h0000_0080, NVPL_ST_OK_REPLY);
      t_csum(32'h0000_0003, NVPL_ST_ERROR);
      t_csum(32'h0000_0000, NVPL_ST_ERROR);
      t_csum(32'h0000_0081, NVPL_ST_ERROR);
      complete_run();
   end
endmodule : nv_param_load_checksum_cmds_tb
